// ### sfl_core.sv
// Purpose: Command handling for status watch, status write and reads
// Assumes: Link pins sampled by sys_clk_i; link clock much slower
// Notes:   Program and erase engines sit outside; busy and arm are ports
//
// Notes on behaviour
// - Opcode 25h starts watching; serial output shows write-in-progress only.
// - While watching, serial input after the opcode is ignored.
// - Watch output follows write-in-progress without clocks, falling with it.
// - Chip select release ends watching and floats the output at once.
// - Opcode 01 writes status only when the write latch is set.
// - Status write data leave bits 15, 10, 1 and 0 untouched.
// - Status write runs only if release follows bit 8 or 16.
// - Eight-bit status write clears invert, quad enable and upper mode bits.
// - Release starts a timed write; busy meanwhile, then write latch clears.
// - Status reads stay answered during a status write cycle.
// - Protect pin and mode bits gate status write; hardware protection refuses.
// - Opcode 03 with 3-byte address; data out until release.
// - Any start address; address advances per byte and wraps to 0.
// - Opcode 0B, address, one dummy byte, then serial data out.
// - While busy, fast, dual-out and dual-io reads are rejected.
// - Opcode 3B, serial address, 8 dummy clocks, two bits per clock.
// - Dual-io read takes address and dummies two bits per clock.
// - Opcode BBh sent serially identifies the dual-io read.
// - Write-in-progress reads 1 while program, erase or status write busy.
module sfl_core import sfl_pkg::*; #(
    parameter int unsigned ADDR_W = 19,
    parameter int unsigned TW_NS  = 10000000
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              io_line_0_i,
    output logic                   io_line_0_o,
    output logic                   io_line_0_oe_o,
    input  wire logic              io_line_1_i,
    output logic                   io_line_1_o,
    output logic                   io_line_1_oe_o,
    input  wire logic              wp_n_i,
    input  wire logic              ext_busy_i,
    input  wire logic              write_arm_i,
    input  wire logic              load_en_i,
    input  wire logic [ADDR_W-1:0] load_addr_i,
    input  wire logic [7:0]        load_data_i,
    output logic      [15:0]       status_o
);
    localparam int unsigned TW_CYC  = (TW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TW_W    = $clog2(TW_CYC + 1);
    localparam logic [TW_W-1:0] TW_LOAD = TW_W'(TW_CYC - 1);

    // Elaboration check
    if (ADDR_W < 3 || ADDR_W > 24) begin : g_bad_addr
        $error("ADDR_W must lie in 3..24");
    end
    if (TW_CYC < 1) begin : g_bad_tw
        $error("TW_NS too small");
    end

    logic              sclk_f;
    logic              cs_n_f;
    logic              io0_f;
    logic              io1_f;
    logic              wp_n_f;
    logic              sclk_prev_q;
    logic              cs_prev_q;
    logic              sck_rise;
    logic              sck_fall;
    logic              cs_rise;
    sfl_state_t        st_q;
    logic [5:0]        cnt_q;
    logic [7:0]        opc_q;
    logic [7:0]        opc_d;
    logic [ADDR_W-1:0] addr_q;
    logic              dual_in_q;
    logic              dual_out_q;
    logic              dummy_q;
    logic              stat_q;
    logic              stat_hi_q;
    logic [15:0]       sh_q;
    logic [15:0]       sr_q;
    logic [15:0]       sr_d;
    logic [15:0]       pend_q;
    logic              wsr_busy_q;
    logic [TW_W-1:0]   tw_q;
    logic              wsr_done;
    logic              wsr_ok;
    logic              write_in_progress;
    logic              hw_prot;
    logic [5:0]        step;
    logic [2:0]        bcnt_q;
    logic [7:0]        osh_q;
    logic [7:0]        src;
    logic [7:0]        cur;
    logic [7:0]        mem_rd;
    logic              io0_q;
    logic              io1_q;

    sfl_sync #(
        .W       (5),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .async_i   ({wp_n_i, io_line_1_i, io_line_0_i, cs_n_i, sclk_i}),
        .sync_o    ({wp_n_f, io1_f, io0_f, cs_n_f, sclk_f})
    );

    sfl_mem #(
        .ADDR_W (ADDR_W)
    ) u_mem (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .rd_addr_i (addr_q),
        .rd_data_o (mem_rd),
        .wr_en_i   (load_en_i),
        .wr_addr_i (load_addr_i),
        .wr_data_i (load_data_i)
    );

    // Edge history of link clock and chip select
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else if (clk_en_i) begin
            sclk_prev_q <= sclk_f;
            cs_prev_q   <= cs_n_f;
        end
    end

    // Edge events, framed by chip select
    assign sck_rise = clk_en_i & ~cs_n_f & sclk_f & ~sclk_prev_q;
    assign sck_fall = clk_en_i & ~cs_n_f & ~sclk_f & sclk_prev_q;
    assign cs_rise  = clk_en_i & cs_n_f & ~cs_prev_q;
    assign opc_d    = {opc_q[6:0], io0_f};
    assign step     = dual_in_q ? STEP_TWO : STEP_ONE;

    // Busy and protection state
    assign write_in_progress      = ext_busy_i | wsr_busy_q;
    assign hw_prot  = sr_q[SB_PROTECT_MODE_HI] | (sr_q[SB_PROTECT_MODE_LO] & ~wp_n_f);
    assign wsr_done = wsr_busy_q && (tw_q == '0);
    assign wsr_ok   = (st_q == ST_SRW) && sr_q[SB_WEL] && !hw_prot && !write_in_progress
                    && (cnt_q == CNT_SR_SHORT || cnt_q == CNT_SR_LONG);

    // Command sequencer
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q       <= ST_OPC;
            cnt_q      <= CNT_ZERO;
            opc_q      <= 8'h00;
            addr_q     <= '0;
            dual_in_q  <= 1'b0;
            dual_out_q <= 1'b0;
            dummy_q    <= 1'b0;
            stat_q     <= 1'b0;
            stat_hi_q  <= 1'b0;
            sh_q       <= 16'h0000;
        end else if (clk_en_i) begin
            if (cs_n_f) begin
                st_q  <= ST_OPC;
                cnt_q <= CNT_ZERO;
            end else if (sck_rise) begin
                case (st_q)
                    ST_OPC: begin
                        opc_q <= opc_d;
                        cnt_q <= cnt_q + STEP_ONE;
                        if (cnt_q == CNT_OPC_LAST) begin
                            cnt_q      <= CNT_ZERO;
                            dual_in_q  <= (opc_d == OP_DUAL_IO);
                            dual_out_q <= (opc_d == OP_DUAL_OUT) || (opc_d == OP_DUAL_IO);
                            dummy_q    <= (opc_d != OP_READ);
                            stat_q     <= 1'b0;
                            stat_hi_q  <= (opc_d == OP_SR_RD_HI);
                            case (opc_d)
                                OP_WATCH:    st_q <= ST_WATCH;
                                OP_SR_WRITE: st_q <= ST_SRW;
                                OP_READ:     st_q <= ST_ADDR;
                                OP_FAST, OP_DUAL_OUT, OP_DUAL_IO: begin
                                    st_q <= write_in_progress ? ST_IGNORE : ST_ADDR;
                                end
                                OP_SR_RD_LO, OP_SR_RD_HI: begin
                                    st_q   <= ST_DATA;
                                    stat_q <= 1'b1;
                                end
                                default:     st_q <= ST_IGNORE;
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        if (dual_in_q) begin
                            addr_q <= {addr_q[ADDR_W-3:0], io1_f, io0_f};
                        end else begin
                            addr_q <= {addr_q[ADDR_W-2:0], io0_f};
                        end
                        cnt_q <= cnt_q + step;
                        if (cnt_q + step == CNT_ADDR) begin
                            cnt_q <= CNT_ZERO;
                            st_q  <= dummy_q ? ST_DUMMY : ST_DATA;
                        end
                    end
                    ST_DUMMY: begin
                        cnt_q <= cnt_q + STEP_ONE;
                        if (cnt_q == CNT_DUM_LAST) begin
                            st_q <= ST_DATA;
                        end
                    end
                    ST_SRW: begin
                        sh_q <= {sh_q[14:0], io0_f};
                        if (cnt_q != CNT_MAX) begin
                            cnt_q <= cnt_q + STEP_ONE;
                        end
                    end
                    ST_WATCH: begin
                        st_q <= ST_WATCH;
                    end
                    default: begin
                        st_q <= st_q;
                    end
                endcase
            end else if (st_q == ST_DATA && sck_fall && bcnt_q == 3'h0 && !stat_q) begin
                addr_q <= addr_q + 1'b1;
            end
        end
    end

    // Byte source and current shift word
    assign src = stat_q ? (stat_hi_q ? sr_q[15:8] : sr_q[7:0]) : mem_rd;
    assign cur = (bcnt_q == 3'h0) ? src : osh_q;

    // Output shifter, falling link clock; watch mirrors busy each cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io1_q  <= 1'b0;
            io0_q  <= 1'b0;
            osh_q  <= 8'h00;
            bcnt_q <= 3'h0;
        end else if (clk_en_i) begin
            if (cs_n_f) begin
                bcnt_q <= 3'h0;
            end else if (st_q != ST_DATA) begin
                io1_q <= write_in_progress;
            end else if (st_q == ST_DATA && sck_fall) begin
                io1_q <= cur[7];
                io0_q <= cur[6];
                if (dual_out_q) begin
                    osh_q  <= {cur[5:0], 2'b00};
                    bcnt_q <= bcnt_q + STEP_TWO[2:0];
                end else begin
                    osh_q  <= {cur[6:0], 1'b0};
                    bcnt_q <= bcnt_q + STEP_ONE[2:0];
                end
            end
        end
    end

    // Pin drivers; enables drop as soon as chip select rises
    assign io_line_1_o    = io1_q;
    assign io_line_0_o    = io0_q;
    assign io_line_1_oe_o = ~cs_n_f & ((st_q == ST_WATCH) | (st_q == ST_DATA));
    assign io_line_0_oe_o = ~cs_n_f & (st_q == ST_DATA) & dual_out_q;

    // Status write acceptance and self-timed cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wsr_busy_q <= 1'b0;
            tw_q       <= '0;
            pend_q     <= SR_RESET;
        end else if (clk_en_i) begin
            if (cs_rise && wsr_ok) begin
                wsr_busy_q <= 1'b1;
                tw_q       <= TW_LOAD;
                if (cnt_q == CNT_SR_SHORT) begin
                    pend_q <= ({sr_q[15:8], sh_q[7:0]} & ~SR_SHORT_CLEAR)
                            | (sr_q & SR_OTP_MASK);
                end else begin
                    pend_q <= {sh_q[7:0], sh_q[15:8]} | (sr_q & SR_OTP_MASK);
                end
            end else if (wsr_done) begin
                wsr_busy_q <= 1'b0;
            end else if (wsr_busy_q) begin
                tw_q <= tw_q - 1'b1;
            end
        end
    end

    // Next status word: apply write at cycle end, arm set beats clear
    always_comb begin
        sr_d = sr_q;
        if (wsr_done) begin
            sr_d = (sr_q & SR_KEEP_MASK) | (pend_q & ~SR_KEEP_MASK);
            sr_d[SB_WEL] = 1'b0;
        end
        if (write_arm_i) begin
            sr_d[SB_WEL] = 1'b1;
        end
        sr_d[SB_WIP] = write_in_progress;
    end

    // Status register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_q <= SR_RESET;
        end else if (clk_en_i) begin
            sr_q <= sr_d;
        end
    end

    assign status_o = sr_q;

    // Watch output falls with busy
    a_watch_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_q == ST_WATCH && !cs_n_f && $fell(write_in_progress)) |=> !io_line_1_o)
        else $error("watch output did not follow busy fall");

    // Release floats both lines
    a_release_float: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(cs_n_f) |-> (!io_line_1_oe_o && !io_line_0_oe_o))
        else $error("lines driven after release");

    // Watch state ignores input traffic
    a_watch_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_q == ST_WATCH && sck_rise) |=> (st_q == ST_WATCH || cs_n_f))
        else $error("watch left while framed");

    // Bad release point discards status write
    a_srw_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && st_q == ST_SRW && !wsr_busy_q
         && cnt_q != CNT_SR_SHORT && cnt_q != CNT_SR_LONG) |=> !wsr_busy_q)
        else $error("status write taken at bad length");

    // Protection or missing latch refuses status write
    a_srw_refuse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && st_q == ST_SRW && !wsr_busy_q && (hw_prot || !sr_q[SB_WEL]))
        |=> !wsr_busy_q)
        else $error("status write taken while refused");

    // Cycle end keeps fixed bits and clears latch
    a_srw_finish: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && wsr_done && !write_arm_i) |=>
        (!sr_q[SB_WEL] && sr_q[SB_SUS1] == $past(sr_q[SB_SUS1])
         && sr_q[SB_SUS2] == $past(sr_q[SB_SUS2])))
        else $error("status write end wrong");

    // Short status write clears three bits
    a_srw_short: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && wsr_ok && cnt_q == CNT_SR_SHORT) |=> ((pend_q & SR_SHORT_CLEAR) == '0))
        else $error("short write kept cleared bits");

    // Busy shows in status while cycle runs
    a_busy_shown: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && wsr_busy_q) |=> sr_q[SB_WIP])
        else $error("busy flag low during cycle");

    // Fast reads rejected while busy
    a_busy_reject: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sck_rise && st_q == ST_OPC && cnt_q == CNT_OPC_LAST && write_in_progress
         && (opc_d == OP_FAST || opc_d == OP_DUAL_OUT || opc_d == OP_DUAL_IO))
        |=> st_q == ST_IGNORE)
        else $error("read accepted while busy");

    // Address advances per byte sent
    a_addr_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_q == ST_DATA && sck_fall && bcnt_q == 3'h0 && !stat_q)
        |=> addr_q == $past(addr_q) + 1'b1)
        else $error("address did not advance");
endmodule

// ### sfl_host.sv
// Purpose: Host model driving the flash link in clock mode 0
// Assumes: Link clock of 8 system clocks (800 ns)
// Notes:   Lines the host releases carry a toggling pattern
module sfl_host (
    input  wire logic sys_clk_i,
    input  wire logic d0_i,
    input  wire logic d0_oe_i,
    input  wire logic d1_i,
    input  wire logic d1_oe_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      io0_o,
    output logic      io1_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic h0 = 1'b0;
    logic h1 = 1'b1;
    // Wire level: the device wins while it drives
    assign io0_o = d0_oe_i ? d0_i : h0;
    assign io1_o = d1_oe_i ? d1_i : h1;
    initial begin
        sclk_o = 1'b0; // Mode 0 idle low, no extra dummy bit
        cs_n_o = 1'b1;
    end
    // Chip select change after a short settle time
    task automatic frame(input logic lvl);
        repeat (4) @(posedge sys_clk_i);
        cs_n_o <= lvl;
    endtask
    // Shift out MSB first; line 1 takes the higher bit of a pair
    task automatic send(input logic [31:0] v, input int n, input bit dual);
        for (int i = n - 1; i >= 0; i--) begin
            if (dual) begin
                h1 <= v[i];
                i--;
            end else begin
                h1 <= ~h1;
            end
            h0 <= v[i];
            repeat (4) @(posedge sys_clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            sclk_o <= 1'b0;
        end
    endtask
    // Sample just before each next falling edge
    task automatic get(input int n, input bit dual, output logic [15:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            h0 <= ~h0;
            h1 <= ~h1;
            repeat (4) @(posedge sys_clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            v = dual ? {v[13:0], io1_o, io0_o} : {v[14:0], io1_o};
            @(posedge sys_clk_i);
            sclk_o <= 1'b0;
        end
    endtask
endmodule

// ### sfl_mem.sv
// Purpose: Byte array behind the read commands
// Assumes: One write port for loading, one registered read port
// Notes:   Read data appear one cycle after the address
module sfl_mem import sfl_pkg::*; #(
    parameter int unsigned ADDR_W = 19
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [7:0]        rd_data_o,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [7:0]        wr_data_i
);
    logic [7:0] mem_q [2**ADDR_W];

    // Elaboration check
    if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
        $error("ADDR_W must lie in 1..24");
    end

    // Array write
    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (clk_en_i) begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule

// ### sfl_pkg.sv
// Purpose: Shared constants and types for the serial flash command block
// Assumes: 10 MHz system clock; one status word of 16 bits
// Notes:   Opcodes, status bit positions and phase lengths live here
package sfl_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Opcodes
    localparam logic [7:0] OP_WATCH     = 8'h25;
    localparam logic [7:0] OP_SR_WRITE  = 8'h01;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_FAST      = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT  = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO   = 8'hbb;
    localparam logic [7:0] OP_SR_RD_LO  = 8'h05;
    localparam logic [7:0] OP_SR_RD_HI  = 8'h35;
    // Status bit positions
    localparam int unsigned SB_WIP  = 0;
    localparam int unsigned SB_WEL  = 1;
    localparam int unsigned SB_PROTECT_MODE_LO = 7;
    localparam int unsigned SB_PROTECT_MODE_HI = 8;
    localparam int unsigned SB_SUS2 = 10;
    localparam int unsigned SB_SUS1 = 15;
    // Status masks and reset value
    localparam logic [15:0] SR_RESET       = 16'h0000;
    localparam logic [15:0] SR_KEEP_MASK   = 16'h8403;
    localparam logic [15:0] SR_SHORT_CLEAR = 16'h4300;
    localparam logic [15:0] SR_OTP_MASK    = 16'h3800;
    // Phase lengths in link clocks or bits
    localparam logic [5:0] CNT_ZERO     = 6'h00;
    localparam logic [5:0] CNT_OPC_LAST = 6'h07;
    localparam logic [5:0] CNT_ADDR     = 6'h18;
    localparam logic [5:0] CNT_DUM_LAST = 6'h07;
    localparam logic [5:0] CNT_SR_SHORT = 6'h08;
    localparam logic [5:0] CNT_SR_LONG  = 6'h10;
    localparam logic [5:0] CNT_MAX      = 6'h3f;
    localparam logic [5:0] STEP_ONE     = 6'h01;
    localparam logic [5:0] STEP_TWO     = 6'h02;
    // Synchroniser reset: {wp_n, io1, io0, cs_n, sclk}
    localparam logic [4:0] SYNC_RST     = 5'h12;

    typedef enum logic [2:0] {
        ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_WATCH, ST_SRW, ST_IGNORE
    } sfl_state_t;
endpackage

// ### sfl_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to sys_clk_i
// Notes:   Output changes only once stages two and three agree
module sfl_sync import sfl_pkg::*; #(
    parameter int unsigned   W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         clk_en_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Elaboration check
    if (W < 1) begin : g_bad_w
        $error("W must be at least 1");
    end

    // Chain and filter; first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q   <= RST_VAL;
            s2_q   <= RST_VAL;
            s3_q   <= RST_VAL;
            sync_o <= RST_VAL;
        end else if (clk_en_i) begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ### tb_serial_flash_status_and_read_cmds.sv
// Purpose: Self-checking bench for the flash command block
// Assumes: Eight-byte array, write cycle of 1000 clocks
// Notes:   Host model drives the link; bench drives side ports
module tb_serial_flash_status_and_read_cmds;
    timeunit 1ns;
    timeprecision 1ns;
    import sfl_pkg::*;
    localparam int unsigned AW = 3;
    logic          sys_clk_i, rst_n_i, ext_busy_i, write_arm_i, load_en_i;
    logic [AW-1:0] load_addr_i;
    logic [7:0]    load_data_i;
    logic [15:0]   status_o, rd;
    logic          sclk, cs_n, io0, io1, d0, d0_oe, d1, d1_oe, clk_en, wp_n;
    int            failures = 0, samples_checked = 0, cycles = 0;
    logic [7:0]    ops[4] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO};

    sfl_core #(.ADDR_W(AW), .TW_NS(100000)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .sclk_i(sclk),
        .cs_n_i(cs_n), .io_line_0_i(io0), .io_line_0_o(d0), .io_line_0_oe_o(d0_oe),
        .io_line_1_i(io1), .io_line_1_o(d1), .io_line_1_oe_o(d1_oe), .wp_n_i(wp_n),
        .ext_busy_i(ext_busy_i), .write_arm_i(write_arm_i), .load_en_i(load_en_i),
        .load_addr_i(load_addr_i), .load_data_i(load_data_i), .status_o(status_o));
    sfl_host host_u (.sys_clk_i(sys_clk_i), .d0_i(d0), .d0_oe_i(d0_oe), .d1_i(d1),
        .d1_oe_i(d1_oe), .sclk_o(sclk), .cs_n_o(cs_n), .io0_o(io0), .io1_o(io1));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // Cut a hang short
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] mb(input int a);
        return 8'h3c ^ 8'((a % 8) * 29);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic arm();
        write_arm_i <= 1'b1;
        tick(1);
        write_arm_i <= 1'b0;
        tick(1);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
        host_u.frame(1'b0);
        host_u.send({24'h0, op}, 8, 1'b0);
        host_u.send({8'h0, a}, n, op == OP_DUAL_IO);
        if (op inside {OP_FAST, OP_DUAL_OUT, OP_DUAL_IO})
            host_u.send(32'h0, op == OP_DUAL_IO ? 16 : 8, op == OP_DUAL_IO);
    endtask
    task automatic t_load();
        for (int i = 0; i < 8; i++) begin
            load_en_i   <= 1'b1;
            load_addr_i <= AW'(i);
            load_data_i <= mb(i);
            tick(1);
        end
        load_en_i <= 1'b0;
    endtask
    // Each read kind from the top address, across the wrap
    task automatic t_reads();
        foreach (ops[i]) begin
            cmd(ops[i], 24'h123457, 24);
            host_u.get(ops[i] inside {OP_DUAL_OUT, OP_DUAL_IO} ? 8 : 16,
                       ops[i] inside {OP_DUAL_OUT, OP_DUAL_IO}, rd);
            chk(rd, {mb(7), mb(0)});
            host_u.frame(1'b1);
            tick(8);
        end
    endtask
    // Fast and dual reads refused while busy
    task automatic t_busy();
        ext_busy_i <= 1'b1;
        tick(3);
        chk(status_o[0], 1'b1);
        for (int i = 1; i < 4; i++) begin
            cmd(ops[i], 24'h000002, 24);
            host_u.get(8, 1'b0, rd);
            chk({d1_oe, d0_oe}, 2'b00);
            host_u.frame(1'b1);
        end
        ext_busy_i <= 1'b0;
        tick(8);
    endtask
    // Status write without latch, then with a bad length
    task automatic t_refused();
        cmd(OP_SR_WRITE, 24'h0000fc, 16);
        host_u.frame(1'b1);
        tick(20);
        chk(status_o, 16'h0000);
        arm();
        cmd(OP_SR_WRITE, 24'h000fcf, 12);
        host_u.frame(1'b1);
        tick(20);
        chk(status_o, 16'h0002);
    endtask
    // Full write, then watch busy fall on the output
    task automatic t_watch();
        cmd(OP_SR_WRITE, 24'h007fc6, 16);
        host_u.frame(1'b1);
        tick(10);
        chk(status_o[1:0], 2'b11);
        cmd(OP_SR_RD_LO, 24'h0, 0);
        host_u.get(8, 1'b0, rd);
        chk(rd, 16'h0003);
        host_u.frame(1'b1);
        tick(8);
        cmd(OP_WATCH, 24'h0, 0);
        tick(10);
        chk({d1, d1_oe}, 2'b11);
        for (int n = 0; n < 1200 && d1 === 1'b1; n++)
            tick(1);
        tick(2);
        chk({d1, d1_oe}, 2'b01);
        chk(status_o, 16'h427c);
        host_u.frame(1'b1);
        tick(8);
        chk(d1_oe, 1'b0);
        cmd(OP_SR_RD_HI, 24'h0, 0);
        host_u.get(8, 1'b0, rd);
        chk(rd, 16'h0042);
        host_u.frame(1'b1);
        tick(8);
    endtask
    // Eight-bit write clears invert, quad and upper mode bits
    task automatic t_short();
        arm();
        cmd(OP_SR_WRITE, 24'h0, 8);
        host_u.frame(1'b1);
        wait_idle();
        chk(status_o, 16'h0000);
    endtask
    // Wait for the self-timed write cycle to end, bounded
    task automatic wait_idle();
        tick(10);
        for (int n = 0; n < 1200 && status_o[0] !== 1'b0; n++)
            tick(1);
    endtask
    // Mode lo with pin low refuses writes; clock enable low freezes the cycle
    task automatic t_protect();
        arm();
        cmd(OP_SR_WRITE, 24'h008000, 16);
        host_u.frame(1'b1);
        wait_idle();
        chk(status_o, 16'h0080);
        wp_n <= 1'b0;
        arm();
        cmd(OP_SR_WRITE, 24'h0, 16);
        host_u.frame(1'b1);
        tick(20);
        chk(status_o, 16'h0082);
        wp_n <= 1'b1;
        cmd(OP_SR_WRITE, 24'h0, 16);
        host_u.frame(1'b1);
        tick(10);
        clk_en <= 1'b0;
        tick(1100);
        chk(status_o[1:0], 2'b11);
        clk_en <= 1'b1;
        wait_idle();
        chk(status_o, 16'h0000);
    endtask
    initial begin
        rst_n_i = 1'b0;
        ext_busy_i = 1'b0;
        write_arm_i = 1'b0;
        load_en_i = 1'b0;
        load_addr_i = '0;
        load_data_i = '0;
        clk_en = 1'b1;
        wp_n = 1'b1;
        tick(12);
        rst_n_i <= 1'b1;
        tick(6);
        chk(status_o, SR_RESET);
        t_load();
        t_reads();
        t_busy();
        t_refused();
        t_watch();
        t_short();
        t_protect();
        stop_test();
    end
endmodule
